// ==== core/nxs_pkg.sv ====
/*
 Package for the nibble XOR / reverse subtract execution datapath:
 opcode patterns, field positions, reset values and packed carriers.
 Assumes a 16-bit instruction word, 7-bit data address, 4-bit data.
*/
package nxs_pkg;
    // ==========================================================
    // Widths and field positions
    localparam int NXS_IW = 16;
    localparam int NXS_AW = 7;
    localparam int NXS_DW = 4;
    localparam int NXS_IMM_LSB = 4;
    localparam int NXS_WR_LSB = 0;
    localparam int NXS_WR_AW = 4;
    // ==========================================================
    // Opcode patterns, aligned to the top bits of the word
    localparam logic [8:0] NXS_OP_XOR_MEM = 9'h070;
    localparam logic [8:0] NXS_OP_XORWB_MEM = 9'h072;
    localparam logic [7:0] NXS_OP_SUBWB_IMM = 8'h1f;
    localparam logic [6:0] NXS_OP_XOR_IMM = 7'h1c;
    localparam logic [6:0] NXS_OP_XORWB_IMM = 7'h1d;
    // ==========================================================
    // Reset values
    localparam logic [3:0] NXS_RST_RESULT = 4'h0;
    localparam logic NXS_RST_FLAG = 1'b0;
    // ==========================================================
    // Carriers
    typedef enum logic [2:0] {
        NXS_NONE, NXS_XOR_MEM, NXS_XORWB_MEM, NXS_XOR_IMM,
        NXS_XORWB_IMM, NXS_SUBWB_IMM
    } nxs_op_t;
    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [3:0] data;
    } nxs_mem_wr_t;
    typedef struct packed {
        logic we;
        logic [3:0] addr;
        logic [3:0] data;
    } nxs_wr_wr_t;
endpackage : nxs_pkg

// ==== core/nxs_decode.sv ====
/*
 Instruction decoder: classifies one 16-bit word into an operation.
 Assumes the fetch logic presents one word per machine cycle.
*/
`timescale 1ns/1ns
module nxs_decode
    import nxs_pkg::*;
(
    input wire logic [15:0] i_insn,
    output nxs_op_t o_op
);
    // ==========================================================
    // Decode
    always_comb begin
        if (i_insn[15:7] == NXS_OP_XOR_MEM) begin
            o_op = NXS_XOR_MEM;
        end else if (i_insn[15:7] == NXS_OP_XORWB_MEM) begin
            o_op = NXS_XORWB_MEM;
        end else if (i_insn[15:8] == NXS_OP_SUBWB_IMM) begin
            o_op = NXS_SUBWB_IMM;
        end else if (i_insn[15:9] == NXS_OP_XOR_IMM) begin
            o_op = NXS_XOR_IMM;
        end else if (i_insn[15:9] == NXS_OP_XORWB_IMM) begin
            o_op = NXS_XORWB_IMM;
        end else begin
            o_op = NXS_NONE;
        end
    end
endmodule : nxs_decode

// ==== core/nxs_exec.sv ====
/*
 Execution datapath for the XOR group and reverse subtract-immediate.
 Assumes the caller supplies the addressed memory nibble and working
 register value combinationally in the cycle the instruction is valid.
*/
//
// Summary of operation
// - Reverse subtract: WR minus immediate into result and WR, carry and zero.
// - Memory XOR result: result gets memory XOR result, zero only.
// - WR XOR immediate into result only, zero flag only.
// - Memory XOR writeback: result to memory and result register.
// - Memory writeback XOR decoded from top nine bits, address below.
// - WR XOR immediate written to WR and result, zero only.
`timescale 1ns/1ns
module nxs_exec
    import nxs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_valid,
    input wire logic [15:0] i_insn,
    input wire logic [3:0] i_mem_rd,
    input wire logic [3:0] i_wr_rd,
    output logic [6:0] o_mem_addr,
    output logic [3:0] o_wr_addr,
    output nxs_mem_wr_t o_mem_wr,
    output nxs_wr_wr_t o_wr_wr,
    output logic [3:0] o_result,
    output logic o_carry,
    output logic o_zero
);
    // ==========================================================
    // Elaboration checks
    // The datapath is hard-wired for nibble data and a 7-bit address
    if (NXS_DW != 4 || NXS_AW != 7 || NXS_IW != 16) begin : g_bad_width
        $error("unsupported datapath widths");
    end
    if (NXS_IMM_LSB + NXS_DW > 8 || NXS_WR_AW != 4) begin : g_bad_field
        $error("unsupported field layout");
    end

    // ==========================================================
    // Reset release
    logic rst_q1;
    logic rst_n;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_q1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n <= rst_q1;
        end
    end

    // ==========================================================
    // Decode and operand addressing
    nxs_op_t op;
    nxs_decode u_dec (
        .i_insn(i_insn),
        .o_op(op)
    );
    logic [3:0] imm;
    logic [6:0] maddr;
    logic [3:0] waddr;
    assign imm = i_insn[NXS_IMM_LSB +: NXS_DW];
    assign maddr = i_insn[NXS_AW-1:0];
    assign waddr = i_insn[NXS_WR_LSB +: NXS_WR_AW];
    // Addresses are combinational from the word so memory reads settle
    // within the same cycle; registered outputs only carry results.
    assign o_mem_addr = maddr;
    assign o_wr_addr = waddr;

    // ==========================================================
    // Arithmetic
    logic [3:0] result_nibble_reg;
    logic carry_borrow_flag;
    logic zero_result_flag;
    nxs_mem_wr_t mem_wr;
    nxs_wr_wr_t wr_wr;
    logic [3:0] next_result;
    logic next_carry;
    logic next_zero;
    nxs_mem_wr_t next_mem_wr;
    nxs_wr_wr_t next_wr_wr;
    logic [4:0] diff;
    logic [3:0] alu;

    always_comb begin
        next_result = result_nibble_reg;
        next_carry = carry_borrow_flag;
        next_zero = zero_result_flag;
        next_mem_wr = '{we: 1'b0, addr: maddr, data: 4'h0};
        next_wr_wr = '{we: 1'b0, addr: waddr, data: 4'h0};
        diff = {1'b0, i_wr_rd} - {1'b0, imm};
        alu = 4'h0;
        if (i_valid) begin
            unique case (op)
                NXS_XOR_MEM, NXS_XORWB_MEM: alu = i_mem_rd ^
                    result_nibble_reg;
                NXS_XOR_IMM, NXS_XORWB_IMM: alu = i_wr_rd ^
                    imm;
                NXS_SUBWB_IMM: alu = diff[3:0];
                NXS_NONE: alu = 4'h0;
            endcase
            if (op != NXS_NONE) begin
                next_result = alu;
                next_zero = (alu == 4'h0);
            end
            if (op == NXS_SUBWB_IMM) begin
                // Carry means no borrow, as for the other subtracts
                next_carry = ~diff[4];
            end
            if (op == NXS_XORWB_MEM) begin
                next_mem_wr.we = 1'b1;
                next_mem_wr.data = alu;
            end
            if (op == NXS_XORWB_IMM || op == NXS_SUBWB_IMM) begin
                next_wr_wr.we = 1'b1;
                next_wr_wr.data = alu;
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            result_nibble_reg <= NXS_RST_RESULT;
            carry_borrow_flag <= NXS_RST_FLAG;
            zero_result_flag <= NXS_RST_FLAG;
            mem_wr <= '0;
            wr_wr <= '0;
        end else begin
            result_nibble_reg <= next_result;
            carry_borrow_flag <= next_carry;
            zero_result_flag <= next_zero;
            mem_wr <= next_mem_wr;
            wr_wr <= next_wr_wr;
        end
    end

    assign o_result = result_nibble_reg;
    assign o_carry = carry_borrow_flag;
    assign o_zero = zero_result_flag;
    assign o_mem_wr = mem_wr;
    assign o_wr_wr = wr_wr;

    // ==========================================================
    // Checks
    property p_sub;
        @(posedge i_clk) disable iff (!rst_n)
        i_valid && op == NXS_SUBWB_IMM |=> o_wr_wr.we &&
        o_result == $past(i_wr_rd) - $past(imm) &&
        o_carry == ($past(i_wr_rd) >= $past(imm));
    endproperty
    a_sub: assert property (p_sub) else $error("sub");
    property p_sub_wb;
        @(posedge i_clk) disable iff (!rst_n)
        i_valid && op == NXS_SUBWB_IMM |=> !o_mem_wr.we &&
        o_wr_wr.addr == $past(waddr) && o_wr_wr.data == o_result;
    endproperty
    a_sub_wb: assert property (p_sub_wb) else $error("sub wb");
    property p_xor_carry;
        @(posedge i_clk) disable iff (!rst_n)
        i_valid && (op == NXS_XOR_IMM || op == NXS_XORWB_IMM ||
        op == NXS_XORWB_MEM) |=> $stable(o_carry);
    endproperty
    a_xor_carry: assert property (p_xor_carry) else $error("carry");
    property p_xorwb_res;
        @(posedge i_clk) disable iff (!rst_n)
        i_valid && op == NXS_XORWB_MEM |=> !o_wr_wr.we &&
        o_result == ($past(i_mem_rd) ^ $past(o_result));
    endproperty
    a_xorwb_res: assert property (p_xorwb_res) else $error("xorwb res");
    property p_xor_mem;
        @(posedge i_clk) disable iff (!rst_n)
        i_valid && op == NXS_XOR_MEM |=> !o_mem_wr.we && !o_wr_wr.we
        && o_result == ($past(i_mem_rd) ^ $past(o_result))
        && $stable(o_carry);
    endproperty
    a_xor_mem: assert property (p_xor_mem) else $error("xor mem");
    property p_xor_imm;
        @(posedge i_clk) disable iff (!rst_n)
        i_valid && op == NXS_XOR_IMM |=> !o_wr_wr.we && !o_mem_wr.we
        && o_result == ($past(i_wr_rd) ^ $past(imm));
    endproperty
    a_xor_imm: assert property (p_xor_imm) else $error("xor imm");
    property p_xorwb_mem;
        @(posedge i_clk) disable iff (!rst_n)
        i_valid && op == NXS_XORWB_MEM |=> o_mem_wr.we &&
        o_mem_wr.data == o_result && o_mem_wr.addr == $past(maddr);
    endproperty
    a_xorwb_mem: assert property (p_xorwb_mem) else $error("xorwb mem");
    property p_dec;
        @(posedge i_clk) disable iff (!rst_n)
        i_insn[15:7] == NXS_OP_XORWB_MEM |-> op == NXS_XORWB_MEM;
    endproperty
    a_dec: assert property (p_dec) else $error("decode");
    property p_xorwb_imm;
        @(posedge i_clk) disable iff (!rst_n)
        i_valid && op == NXS_XORWB_IMM |=> o_wr_wr.we &&
        o_wr_wr.data == ($past(i_wr_rd) ^ $past(imm)) &&
        o_wr_wr.addr == $past(waddr) && $stable(o_carry);
    endproperty
    a_xorwb_imm: assert property (p_xorwb_imm) else $error("xorwb imm");
    property p_zero;
        @(posedge i_clk) disable iff (!rst_n)
        i_valid && op != NXS_NONE |=> o_zero == (o_result == 4'h0);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag");
    property p_idle;
        @(posedge i_clk) disable iff (!rst_n)
        !i_valid |=> !o_mem_wr.we && !o_wr_wr.we && $stable(o_result);
    endproperty
    a_idle: assert property (p_idle) else $error("idle write");
    c_sub: cover property (@(posedge i_clk) i_valid && op == NXS_SUBWB_IMM);
    c_wbm: cover property (@(posedge i_clk) i_valid && op == NXS_XORWB_MEM);
    c_zero: cover property (@(posedge i_clk) o_zero && o_wr_wr.we);
    c_borrow: cover property (@(posedge i_clk)
        i_valid && op == NXS_SUBWB_IMM && i_wr_rd < imm);
    c_ximm: cover property (@(posedge i_clk) i_valid && op == NXS_XORWB_IMM);
endmodule : nxs_exec

// ==== verification/nibble_xor_subtract_exec_test.sv ====
/*
 Self-checking bench for nxs_exec: random and corner instruction streams.
 Assumes nxs_pkg and nxs_exec are compiled before this file.
*/
`timescale 1ns/1ns
module nibble_xor_subtract_exec_test;
    import nxs_pkg::*;
    logic i_clk, i_nrst, i_valid, o_carry, o_zero, cf, zf;
    logic [15:0] i_insn;
    logic [3:0] i_mem_rd, i_wr_rd, o_wr_addr, o_result, acc;
    logic [6:0] o_mem_addr;
    nxs_mem_wr_t o_mem_wr;
    nxs_wr_wr_t o_wr_wr;
    logic [31:0] seed = 32'h51;
    int error_cnt = 0;
    int num_checks = 0;

    nxs_exec dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_valid(i_valid),
        .i_insn(i_insn), .i_mem_rd(i_mem_rd), .i_wr_rd(i_wr_rd),
        .o_mem_addr(o_mem_addr), .o_wr_addr(o_wr_addr),
        .o_mem_wr(o_mem_wr), .o_wr_wr(o_wr_wr), .o_result(o_result),
        .o_carry(o_carry), .o_zero(o_zero));

    // ==========================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict

    task automatic do_reset();
        @(negedge i_clk);
        i_nrst = 1'b0;
        i_valid = 1'b0;
        repeat (12) @(posedge i_clk);
        @(negedge i_clk);
        i_nrst = 1'b1;
        repeat (3) @(posedge i_clk);
        #1;
        acc = 4'h0;
        cf = 1'b0;
        zf = 1'b0;
        chk({o_result, o_carry, o_zero, o_mem_wr.we, o_wr_wr.we}, 16'h0);
    endtask : do_reset

    // ==========================================================
    // One instruction: 0 idle, 1-5 the five ops, 6 unknown opcode
    task automatic run_op(input int k, input logic [3:0] m,
                          input logic [3:0] w, input logic [3:0] im);
        logic [31:0] q;
        logic [3:0] r;
        logic em, ew;
        q = rnd();
        r = acc;
        em = 1'b0;
        ew = 1'b0;
        @(negedge i_clk);
        i_mem_rd = m;
        i_wr_rd = w;
        i_valid = (k != 0);
        i_insn = (k == 0) ? {9'h072, q[6:0]} : 16'h0000;
        case (k)
            1, 2: begin
                i_insn = {(k == 1) ? 9'h070 : 9'h072, q[6:0]};
                r = m ^ acc;
                em = (k == 2);
            end
            3, 4: begin
                // I3 set keeps the plain form clear of memory opcodes
                if (k == 3) im[3] = 1'b1;
                i_insn = {(k == 3) ? 7'h1c : 7'h1d, 1'b0, im, q[3:0]};
                r = w ^ im;
                ew = (k == 4);
            end
            5: begin
                i_insn = {8'h1f, im, q[3:0]};
                r = w - im;
                cf = (w >= im);
                ew = 1'b1;
            end
            default: ;
        endcase
        #1;
        chk(o_mem_addr, i_insn[6:0]);
        chk(o_wr_addr, i_insn[3:0]);
        @(posedge i_clk);
        #1;
        if (k >= 1 && k <= 5) zf = (r == 4'h0);
        acc = r;
        chk(o_result, acc);
        chk(o_zero, zf);
        chk(o_carry, cf);
        chk(o_mem_wr.we, em);
        if (em) chk(o_mem_wr, {em, i_insn[6:0], r});
        chk(o_wr_wr.we, ew);
        if (ew) chk(o_wr_wr, {ew, i_insn[3:0], r});
    endtask : run_op

    // ==========================================================
    // Clock, watchdog, main sequence
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    initial begin
        #100000;
        error_cnt++;
        print_verdict();
    end

    initial begin
        logic [31:0] q;
        i_nrst = 1'b0;
        i_valid = 1'b0;
        i_insn = 16'h0;
        i_mem_rd = 4'h0;
        i_wr_rd = 4'h0;
        do_reset();
        run_op(5, 4'h0, 4'h0, 4'h0);
        run_op(5, 4'h0, 4'h0, 4'h1);
        run_op(5, 4'h0, 4'hf, 4'hf);
        run_op(1, acc, 4'h0, 4'h0);
        run_op(4, 4'h0, 4'h9, 4'h9);
        run_op(3, 4'h0, 4'hc, 4'hc);
        run_op(2, acc, 4'h0, 4'h0);
        for (int k = 0; k < 7; k++) run_op(k, 4'h6, 4'h3, 4'h5);
        // Mid-run reset must clear result, flags and strobes
        do_reset();
        repeat (800) begin
            q = rnd();
            run_op(q % 7, q[7:4], q[11:8], q[15:12]);
        end
        print_verdict();
    end
endmodule : nibble_xor_subtract_exec_test
